//--- qpwrb_pkg.sv
package qpwrb_pkg;
	// Instruction opcodes carried in the upper nibble of the instruction byte.
	localparam logic [3:0] OP_READ_WIPER = 4'h9;
	localparam logic [3:0] OP_WRITE_WIPER = 4'ha;
	localparam logic [3:0] OP_READ_SET = 4'hb;
	localparam logic [3:0] OP_WRITE_SET = 4'hc;
	localparam logic [3:0] OP_LOAD_WIPER = 4'hd;
	localparam logic [3:0] OP_SAVE_WIPER = 4'he;
	localparam logic [3:0] OP_GLOAD_ALL = 4'h1;
	localparam logic [3:0] OP_GSAVE_ALL = 4'h8;
	localparam logic [3:0] OP_INCDEC = 4'h2;
	localparam logic [3:0] OP_READ_STATUS = 4'h6;

	// Identification byte: device type value is arbitrary, upper address bits fixed.
	localparam logic [3:0] DEV_TYPE = 4'h3;
	localparam logic [1:0] ADDR_HI = 2'h0;

	// Field positions inside the instruction byte.
	localparam int OPC_LSB = 4;
	localparam int SEL_LSB = 2;
	localparam int CH_LSB = 0;

	// Register geometry and values after reset.
	localparam int CHANNELS = 4;
	localparam int TAPS = 256;
	localparam logic [7:0] WIPER_RST = 8'h00;
	localparam logic [7:0] SETTING_RST = 8'h80;
	localparam logic [7:0] WIPER_MAX = 8'hff;
	localparam logic [7:0] WIPER_MIN = 8'h00;
	localparam logic [2:0] BIT_LAST = 3'h7;

	// Non-volatile write time and its cycle count at the system clock rate.
	localparam int NV_WRITE_TIME_MS = 10;
	localparam int SYS_CLK_KHZ = 250000;
	localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_MS * SYS_CLK_KHZ;
	localparam int NV_CNT_W = 22;

	// Width of the gray-coded step counters that cross to the system clock.
	localparam int STEP_W = 4;

	// Serial link sequence states.
	typedef enum logic [2:0] {LS_ID, LS_INSTR, LS_WDATA, LS_READ, LS_STEP, LS_IDLE} qpwrb_link_st_t;
endpackage

//--- qpwrb_nv_timer.sv
`timescale 1ns/10ps
module qpwrb_nv_timer #(
	parameter int unsigned CYCLES = qpwrb_pkg::NV_WRITE_CYCLES
) (
	input wire logic sys_clk, // System clock.
	input wire logic rst_n, // Synchronous reset, active low.
	input wire logic clk_en, // Freezes the timer while low.
	input wire logic start, // Begins one write cycle when idle.
	output logic busy, // High while a write cycle runs.
	output logic done // One-cycle pulse on the last cycle.
);
	localparam logic [qpwrb_pkg::NV_CNT_W-1:0] LAST = qpwrb_pkg::NV_CNT_W'(CYCLES - 1);

	logic [qpwrb_pkg::NV_CNT_W-1:0] cnt_r;
	logic busy_r;

	// A start while busy is dropped; the caller never issues one then.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			busy_r <= 1'b0;
			cnt_r <= '0;
		end else if (clk_en) begin
			if (start && !busy_r) begin
				busy_r <= 1'b1;
				cnt_r <= '0;
			end else if (done) begin
				busy_r <= 1'b0;
			end else if (busy_r) begin
				cnt_r <= cnt_r + 1'b1;
			end
		end
	end

	assign busy = busy_r;
	assign done = busy_r && (cnt_r == LAST);

	a_busy_after_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && start && !busy_r) |=> busy_r && (cnt_r == '0))
		else $error("write busy did not rise after start");
	a_busy_bounded: assert property (@(posedge sys_clk) disable iff (!rst_n)
		busy_r |-> (cnt_r <= LAST))
		else $error("write cycle ran past its limit");
endmodule

//--- qpwrb_bank.sv
`timescale 1ns/10ps
// Notes on behaviour
// - Read bits leave on serial clock falling edges.
// - Serial input sampled on rising serial clock edges.
// - Pause low freezes the sequence, keeps its state.
// - Chip select high: output floats, standby unless writing.
// - Chip select low: device active.
// - Nothing runs before first chip select falling edge.
// - Address pins must match the received slave address.
// - Write protect low blocks all setting writes.
// - Each wiper register selects one of 256 taps.
// - Write-wiper command loads wiper from serial data.
// - Transfer command loads wiper from chosen setting.
// - Increment/decrement moves wiper one step each.
// - Reset loads each wiper from setting zero.
// - Four readable, writable settings per channel.
// - Setting changes are timed writes, at most 10 ms.
// - Each setting holds one 8-bit value.
// - Busy flag high exactly while a write runs; write_busy_flag is registered and trails it by one system clock.
// - First byte: device type nibble, then slave address.
// - Select bits 00 to 11 pick settings zero to three.
// - Serial input high steps up, low steps down.
module qpwrb_bank #(
	parameter int unsigned NV_WRITE_CYCLES = qpwrb_pkg::NV_WRITE_CYCLES
) (
	input wire logic sys_clk, // System clock, 250 MHz.
	input wire logic rst_n, // Synchronous reset, active low.
	input wire logic clk_en, // Freezes system-side state while low.
	input wire logic spi_sck, // Serial clock from the host.
	input wire logic cs_n, // Chip select, active low.
	input wire logic serial_in, // Serial data from the host.
	output logic serial_out, // Serial data to the host.
	output logic serial_out_oe, // High while serial_out is driven.
	input wire logic pause_n, // Pause input, active low.
	input wire logic write_protect_n, // Blocks setting writes when low.
	input wire logic [1:0] addr_pins, // Low two slave address bits.
	output logic [qpwrb_pkg::CHANNELS*qpwrb_pkg::TAPS-1:0] tap_sel, // One-hot tap select per channel.
	output logic [qpwrb_pkg::CHANNELS*8-1:0] wiper_pos, // Wiper positions, channel 0 lowest.
	output logic write_busy_flag, // Non-volatile write in progress.
	output logic active_mode, // Device selected.
	output logic standby // Deselected with no write running.
);
	// Gray conversion is used on both sides of the crossing.
	function automatic logic [qpwrb_pkg::STEP_W-1:0] bin2gray(input logic [qpwrb_pkg::STEP_W-1:0] b);
		bin2gray = b ^ (b >> 1);
	endfunction

	function automatic logic [qpwrb_pkg::STEP_W-1:0] gray2bin(input logic [qpwrb_pkg::STEP_W-1:0] g);
		logic [qpwrb_pkg::STEP_W-1:0] b;
		b = g;
		for (int i = qpwrb_pkg::STEP_W - 2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		gray2bin = b;
	endfunction

	function automatic logic [qpwrb_pkg::TAPS-1:0] onehot(input logic [7:0] w);
		onehot = qpwrb_pkg::TAPS'(1) << w;
	endfunction

	// System-side storage.
	logic [7:0] wiper_r [qpwrb_pkg::CHANNELS];
	logic [7:0] setting_r [qpwrb_pkg::CHANNELS*4];
	logic nv_busy;

	// Link-side state.
	qpwrb_pkg::qpwrb_link_st_t lstate_r;
	logic [2:0] bit_cnt_r;
	logic [6:0] shift_r;
	logic [7:0] instr_r;
	logic [7:0] data_r;
	logic [7:0] rd_byte_r;
	logic cmd_valid_r;
	logic [1:0] addr_m_r;
	logic [1:0] addr_s_r;
	logic busy_m_r;
	logic busy_s_r;
	logic [qpwrb_pkg::STEP_W-1:0] up_bin_r;
	logic [qpwrb_pkg::STEP_W-1:0] dn_bin_r;
	logic [qpwrb_pkg::STEP_W-1:0] up_g_r;
	logic [qpwrb_pkg::STEP_W-1:0] dn_g_r;
	logic so_r;
	logic so_oe_r;
	logic [7:0] nb;
	logic byte_done;

	assign nb = {shift_r, serial_in};
	assign byte_done = (bit_cnt_r == qpwrb_pkg::BIT_LAST);

	// Straps and the busy flag are resampled on the serial clock before use.
	always_ff @(posedge spi_sck) begin
		addr_m_r <= addr_pins;
		addr_s_r <= addr_m_r;
		busy_m_r <= nv_busy;
		busy_s_r <= busy_m_r;
	end

	// Bit shifting; the frame resets it and a pause holds it where it is.
	always_ff @(posedge spi_sck or posedge cs_n) begin
		if (cs_n) begin
			bit_cnt_r <= 3'h0;
			shift_r <= 7'h00;
		end else if (pause_n) begin
			bit_cnt_r <= bit_cnt_r + 3'h1;
			shift_r <= nb[6:0];
		end
	end

	// Command words are kept past the frame end so the system side can still read them.
	always_ff @(posedge spi_sck) begin
		if (!cs_n && pause_n && byte_done) begin
			if (lstate_r == qpwrb_pkg::LS_INSTR) begin
				instr_r <= nb;
			end
			if (lstate_r == qpwrb_pkg::LS_WDATA) begin
				data_r <= nb;
			end
		end
	end

	// Frame sequence: identification, instruction, then data, read or stepping.
	always_ff @(posedge spi_sck or posedge cs_n) begin
		if (cs_n) begin
			lstate_r <= qpwrb_pkg::LS_ID;
			cmd_valid_r <= 1'b0;
			rd_byte_r <= 8'h00;
		end else if (pause_n && byte_done) begin
			case (lstate_r)
				qpwrb_pkg::LS_ID: begin
					if (nb[7:4] == qpwrb_pkg::DEV_TYPE && nb[3:0] == {qpwrb_pkg::ADDR_HI, addr_s_r}) begin
						lstate_r <= qpwrb_pkg::LS_INSTR;
					end else begin
						lstate_r <= qpwrb_pkg::LS_IDLE;
					end
				end
				qpwrb_pkg::LS_INSTR: begin
					case (nb[7:4])
						qpwrb_pkg::OP_READ_WIPER: begin
							rd_byte_r <= wiper_r[nb[1:0]];
							lstate_r <= qpwrb_pkg::LS_READ;
						end
						qpwrb_pkg::OP_READ_SET: begin
							rd_byte_r <= setting_r[{nb[1:0], nb[3:2]}];
							lstate_r <= qpwrb_pkg::LS_READ;
						end
						qpwrb_pkg::OP_READ_STATUS: begin
							rd_byte_r <= {7'h00, busy_s_r};
							lstate_r <= qpwrb_pkg::LS_READ;
						end
						qpwrb_pkg::OP_WRITE_WIPER, qpwrb_pkg::OP_WRITE_SET: begin
							lstate_r <= qpwrb_pkg::LS_WDATA;
						end
						qpwrb_pkg::OP_LOAD_WIPER, qpwrb_pkg::OP_SAVE_WIPER, qpwrb_pkg::OP_GLOAD_ALL,
						qpwrb_pkg::OP_GSAVE_ALL: begin
							cmd_valid_r <= 1'b1;
							lstate_r <= qpwrb_pkg::LS_IDLE;
						end
						qpwrb_pkg::OP_INCDEC: begin
							cmd_valid_r <= 1'b1;
							lstate_r <= qpwrb_pkg::LS_STEP;
						end
						default: begin
							lstate_r <= qpwrb_pkg::LS_IDLE;
						end
					endcase
				end
				qpwrb_pkg::LS_WDATA: begin
					cmd_valid_r <= 1'b1;
					lstate_r <= qpwrb_pkg::LS_IDLE;
				end
				qpwrb_pkg::LS_READ: begin
					lstate_r <= qpwrb_pkg::LS_IDLE;
				end
				default: begin
					lstate_r <= lstate_r;
				end
			endcase
		end
	end

	// Each stepping pulse bumps a gray counter; only one bit changes per step.
	always_ff @(posedge spi_sck or posedge cs_n) begin
		if (cs_n) begin
			up_bin_r <= '0;
			dn_bin_r <= '0;
			up_g_r <= '0;
			dn_g_r <= '0;
		end else if (pause_n && lstate_r == qpwrb_pkg::LS_STEP) begin
			if (serial_in) begin
				up_bin_r <= up_bin_r + 1'b1;
				up_g_r <= bin2gray(up_bin_r + 1'b1);
			end else begin
				dn_bin_r <= dn_bin_r + 1'b1;
				dn_g_r <= bin2gray(dn_bin_r + 1'b1);
			end
		end
	end

	// Read data changes on falling edges so the host samples it on the next rising edge.
	always_ff @(negedge spi_sck or posedge cs_n) begin
		if (cs_n) begin
			so_r <= 1'b0;
			so_oe_r <= 1'b0;
		end else if (pause_n) begin
			so_oe_r <= (lstate_r == qpwrb_pkg::LS_READ);
			so_r <= rd_byte_r[qpwrb_pkg::BIT_LAST - bit_cnt_r];
		end
	end

	// The pin floats whenever deselected or paused.
	assign serial_out = so_r;
	assign serial_out_oe = so_oe_r && pause_n && !cs_n;

	// Two-flop synchronisers for chip select, command valid, write protect and the step counters.
	logic cs_m_r, cs_s_r, cmdv_m_r, cmdv_s_r, cmdv_d_r, wp_m_r, wp_s_r;
	logic [qpwrb_pkg::STEP_W-1:0] up_m_r, up_s_r, dn_m_r, dn_s_r;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cs_m_r <= 1'b0; // A real high level must be seen after reset before arming.
			cs_s_r <= 1'b0;
			cmdv_m_r <= 1'b0;
			cmdv_s_r <= 1'b0;
			cmdv_d_r <= 1'b0;
			wp_m_r <= 1'b0;
			wp_s_r <= 1'b0;
			up_m_r <= '0;
			up_s_r <= '0;
			dn_m_r <= '0;
			dn_s_r <= '0;
		end else if (clk_en) begin
			cs_m_r <= cs_n;
			cs_s_r <= cs_m_r;
			cmdv_m_r <= cmd_valid_r;
			cmdv_s_r <= cmdv_m_r;
			cmdv_d_r <= cmdv_s_r;
			wp_m_r <= write_protect_n;
			wp_s_r <= wp_m_r;
			up_m_r <= up_g_r;
			up_s_r <= up_m_r;
			dn_m_r <= dn_g_r;
			dn_s_r <= dn_m_r;
		end
	end

	// Commands are ignored until chip select has been seen high and then low.
	logic saw_high_r, armed_r;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			saw_high_r <= 1'b0;
			armed_r <= 1'b0;
		end else if (clk_en) begin
			if (cs_s_r) begin
				saw_high_r <= 1'b1;
			end else if (saw_high_r) begin
				armed_r <= 1'b1;
			end
		end
	end

	logic cmd_go;
	logic [3:0] op;
	logic [1:0] sel;
	logic [1:0] ch;
	assign cmd_go = clk_en && armed_r && cmdv_s_r && !cmdv_d_r;
	assign op = instr_r[qpwrb_pkg::OPC_LSB +: 4];
	assign sel = instr_r[qpwrb_pkg::SEL_LSB +: 2];
	assign ch = instr_r[qpwrb_pkg::CH_LSB +: 2];

	// Stepping: applied counts chase the synchronised link counts one per cycle.
	logic step_en_r;
	logic [1:0] step_ch_r;
	logic [qpwrb_pkg::STEP_W-1:0] up_done_r, dn_done_r;
	logic step_up, step_dn;
	assign step_up = clk_en && step_en_r && !cs_s_r && (up_done_r != gray2bin(up_s_r));
	assign step_dn = clk_en && step_en_r && !cs_s_r && !step_up && (dn_done_r != gray2bin(dn_s_r));
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			step_en_r <= 1'b0;
			step_ch_r <= 2'h0;
			up_done_r <= '0;
			dn_done_r <= '0;
		end else if (clk_en) begin
			if (cs_s_r) begin
				step_en_r <= 1'b0;
				up_done_r <= '0;
				dn_done_r <= '0;
			end else if (cmd_go && op == qpwrb_pkg::OP_INCDEC) begin
				step_en_r <= 1'b1;
				step_ch_r <= ch;
			end else if (step_up) begin
				up_done_r <= up_done_r + 1'b1;
			end else if (step_dn) begin
				dn_done_r <= dn_done_r + 1'b1;
			end
		end
	end

	// Wiper registers: recall after reset, serial load, parallel load and stepping.
	logic recall_r;
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			recall_r <= 1'b1;
			for (int i = 0; i < qpwrb_pkg::CHANNELS; i++) begin
				wiper_r[i] <= qpwrb_pkg::WIPER_RST;
			end
		end else if (clk_en) begin
			recall_r <= 1'b0;
			if (recall_r) begin
				for (int i = 0; i < qpwrb_pkg::CHANNELS; i++) begin
					wiper_r[i] <= setting_r[i*4];
				end
			end else if (cmd_go && op == qpwrb_pkg::OP_WRITE_WIPER) begin
				wiper_r[ch] <= data_r;
			end else if (cmd_go && op == qpwrb_pkg::OP_LOAD_WIPER) begin
				wiper_r[ch] <= setting_r[{ch, sel}];
			end else if (cmd_go && op == qpwrb_pkg::OP_GLOAD_ALL) begin
				for (int i = 0; i < qpwrb_pkg::CHANNELS; i++) begin
					wiper_r[i] <= setting_r[{2'(i), sel}];
				end
			end else if (step_up && wiper_r[step_ch_r] != qpwrb_pkg::WIPER_MAX) begin
				wiper_r[step_ch_r] <= wiper_r[step_ch_r] + 8'h01;
			end else if (step_dn && wiper_r[step_ch_r] != qpwrb_pkg::WIPER_MIN) begin
				wiper_r[step_ch_r] <= wiper_r[step_ch_r] - 8'h01;
			end
		end
	end

	// Setting writes: data is latched at start and committed when the write time ends.
	logic nv_start, nv_done;
	logic [1:0] pend_sel_r;
	logic [3:0] pend_mask_r;
	logic [7:0] pend_data_r [qpwrb_pkg::CHANNELS];
	assign nv_start = cmd_go && wp_s_r && !nv_busy && (op == qpwrb_pkg::OP_WRITE_SET ||
		op == qpwrb_pkg::OP_SAVE_WIPER || op == qpwrb_pkg::OP_GSAVE_ALL);
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			pend_sel_r <= 2'h0;
			pend_mask_r <= 4'h0;
			for (int i = 0; i < qpwrb_pkg::CHANNELS; i++) begin
				pend_data_r[i] <= qpwrb_pkg::SETTING_RST;
			end
		end else if (nv_start) begin
			pend_sel_r <= sel;
			pend_mask_r <= (op == qpwrb_pkg::OP_GSAVE_ALL) ? 4'hf : 4'(1 << ch);
			for (int i = 0; i < qpwrb_pkg::CHANNELS; i++) begin
				pend_data_r[i] <= (op == qpwrb_pkg::OP_WRITE_SET) ? data_r :
					(op == qpwrb_pkg::OP_SAVE_WIPER) ? wiper_r[ch] : wiper_r[i];
			end
		end
	end

	// Settings reset to a default value; the committed byte lands on the last write cycle.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < qpwrb_pkg::CHANNELS*4; i++) begin
				setting_r[i] <= qpwrb_pkg::SETTING_RST;
			end
		end else if (clk_en && nv_done) begin
			for (int i = 0; i < qpwrb_pkg::CHANNELS; i++) begin
				if (pend_mask_r[i]) begin
					setting_r[{2'(i), pend_sel_r}] <= pend_data_r[i];
				end
			end
		end
	end

	qpwrb_nv_timer #(
		.CYCLES(NV_WRITE_CYCLES)
	) u_nv_timer (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.clk_en(clk_en),
		.start(nv_start),
		.busy(nv_busy),
		.done(nv_done)
	);

	// Tap decode and published state are registered.
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			tap_sel <= '0;
			wiper_pos <= '0;
			write_busy_flag <= 1'b0;
			active_mode <= 1'b0;
			standby <= 1'b1;
		end else if (clk_en) begin
			for (int i = 0; i < qpwrb_pkg::CHANNELS; i++) begin
				tap_sel[i*qpwrb_pkg::TAPS +: qpwrb_pkg::TAPS] <= onehot(wiper_r[i]);
				wiper_pos[i*8 +: 8] <= wiper_r[i];
			end
			write_busy_flag <= nv_busy;
			active_mode <= !cs_s_r;
			standby <= cs_s_r && !nv_busy;
		end
	end

	a_wp_blocks_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!wp_s_r |-> !nv_start)
		else $error("setting write started while protected");
	a_unarmed_no_start: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!armed_r |-> !nv_start && !cmd_go)
		else $error("command accepted before chip select fell");
	a_write_wiper_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(cmd_go && op == qpwrb_pkg::OP_WRITE_WIPER && !recall_r) |=> wiper_r[$past(ch)] == $past(data_r))
		else $error("wiper not loaded from serial data");
	a_xfr_parallel_load: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(cmd_go && op == qpwrb_pkg::OP_LOAD_WIPER && !recall_r) |=> wiper_r[ch] == setting_r[{ch, sel}])
		else $error("wiper not loaded from setting");
	a_recall_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(recall_r && clk_en) |=> wiper_r[0] == setting_r[0] && wiper_r[3] == setting_r[12])
		else $error("wiper not recalled from setting zero");
	a_step_up_one: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(step_up && !cmd_go && !recall_r && wiper_r[step_ch_r] != qpwrb_pkg::WIPER_MAX)
		|=> wiper_r[step_ch_r] == $past(wiper_r[step_ch_r]) + 8'h01)
		else $error("wiper did not step up by one");
	a_step_saturate: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(step_dn && !cmd_go && !recall_r && wiper_r[step_ch_r] == qpwrb_pkg::WIPER_MIN)
		|=> wiper_r[step_ch_r] == qpwrb_pkg::WIPER_MIN)
		else $error("wiper wrapped below zero");
	a_out_floats: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cs_n |-> !serial_out_oe)
		else $error("serial output driven while deselected");
	a_busy_flag_follows: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(clk_en && nv_start) |=> ##1 write_busy_flag)
		else $error("busy flag missed a write cycle");
endmodule

//--- qpwrb_host.sv
`timescale 1ns/10ps
// Behavioural serial host; its clock runs only inside frames, at a 15 ns period.
module qpwrb_host (
	output logic spi_sck, // Serial clock.
	output logic cs_n, // Chip select, active low.
	output logic serial_in, // Data to the device.
	output logic pause_n, // Pause, active low.
	input wire logic serial_out, // Data from the device.
	output logic [7:0] rd_data, // Last byte sampled in the data slot.
	output logic rd_stb // Short pulse once a read byte is complete.
);
	// Idle levels; pause stays high unless a frame asks for it.
	initial begin
		spi_sck = 1'b0;
		cs_n = 1'b1;
		serial_in = 1'b0;
		pause_n = 1'b1;
		rd_data = 8'h00;
		rd_stb = 1'b0;
	end

	// One frame: two header bytes, then n bits of dat, MSB first.
	task automatic frame(input logic [7:0] id, ins, dat, input int n, input bit rd, input bit hold);
		logic [23:0] sh;
		sh = {id, ins, dat};
		cs_n = 1'b0;
		#20;
		for (int i = 0; i < 16 + n; i++) begin
			serial_in = sh[23-i];
			if (hold && i == 12) begin
				pause_n = 1'b0;
				#100;
				pause_n = 1'b1;
				#10;
			end
			#7.5 spi_sck = 1'b1;
			if (i >= 16) begin
				rd_data = {rd_data[6:0], serial_out};
			end
			#7.5 spi_sck = 1'b0;
		end
		#15 cs_n = 1'b1;
		// A released line must not keep showing the last bit.
		serial_in = ~serial_in;
		if (rd) begin
			rd_stb = 1'b1;
			#1 rd_stb = 1'b0;
		end
		#30;
	endtask
endmodule

//--- qpwrb_bank_tb.sv
`timescale 1ns/10ps
module qpwrb_bank_tb;
	localparam int NVC = 40;
	logic sys_clk = 1'b0;
	logic rst_n, clk_en, write_protect_n;
	logic [1:0] addr_pins, addr;
	wire spi_sck, cs_n, serial_in, pause_n, serial_out, serial_out_oe, rd_stb;
	wire [7:0] rd_data;
	wire [1023:0] tap_sel;
	wire [31:0] wiper_pos;
	wire write_busy_flag, active_mode, standby;
	logic [7:0] wp [4];
	logic [7:0] st [4][4];
	logic [7:0] exp_q [$];
	logic [7:0] v;
	int seed, error_cnt, checks;

	qpwrb_bank #(.NV_WRITE_CYCLES(NVC)) qpwrb_bank_inst (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en),
		.spi_sck(spi_sck), .cs_n(cs_n), .serial_in(serial_in), .serial_out(serial_out),
		.serial_out_oe(serial_out_oe), .pause_n(pause_n), .write_protect_n(write_protect_n),
		.addr_pins(addr_pins), .tap_sel(tap_sel), .wiper_pos(wiper_pos), .write_busy_flag(write_busy_flag),
		.active_mode(active_mode), .standby(standby));
	qpwrb_host qpwrb_host_inst (.spi_sck(spi_sck), .cs_n(cs_n), .serial_in(serial_in), .pause_n(pause_n),
		.serial_out(serial_out), .rd_data(rd_data), .rd_stb(rd_stb));

	// System clock, 250 MHz.
	always #2 sys_clk = ~sys_clk;

	task automatic chk(input logic [7:0] got, exp);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic complete_run();
		$display("checks=%0d errors=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// Every read byte is matched against the oldest note, in issue order.
	always @(posedge rd_stb) begin
		chk(rd_data, exp_q.pop_front());
	end

	// While paused the device stays selected but must not drive its output.
	always @(negedge pause_n) begin
		repeat (6) @(posedge sys_clk);
		chk({7'h0, active_mode}, 8'h01);
		chk({7'h0, serial_out_oe}, 8'h00);
	end

	task automatic cmd(input logic [3:0] op, input logic [1:0] sel, ch, input logic [7:0] dat);
		logic rd;
		int n;
		rd = op inside {qpwrb_pkg::OP_READ_WIPER, qpwrb_pkg::OP_READ_SET, qpwrb_pkg::OP_READ_STATUS};
		n = op inside {qpwrb_pkg::OP_LOAD_WIPER, qpwrb_pkg::OP_SAVE_WIPER, qpwrb_pkg::OP_GLOAD_ALL,
			qpwrb_pkg::OP_GSAVE_ALL} ? 0 : 8;
		qpwrb_host_inst.frame({qpwrb_pkg::DEV_TYPE, qpwrb_pkg::ADDR_HI, addr}, {op, sel, ch}, dat, n, rd, 1'b0);
	endtask

	task automatic settle();
		repeat (16) @(posedge sys_clk);
	endtask

	// Wiper value and its one-hot tap, then the idle state of the port.
	task automatic chk_wp();
		for (int c = 0; c < 4; c++) begin
			chk(wiper_pos[c*8+:8], wp[c]);
			chk({7'h0, tap_sel[c*256+:256] === (256'h1 << wp[c])}, 8'h01);
		end
		chk({7'h0, serial_out_oe}, 8'h00);
		chk({7'h0, active_mode}, 8'h00);
	endtask

	// The first loop is an observation window: a refused write never raises busy.
	task automatic nv_wait(input bit run);
		int n;
		n = 0;
		while (write_busy_flag !== 1'b1 && n < 40) begin
			@(posedge sys_clk);
			n++;
		end
		chk({7'h0, n < 40}, {7'h0, run});
		if (n < 40) chk({7'h0, standby}, 8'h00);
		n = 0;
		while (write_busy_flag !== 1'b0 && n < 200) begin
			@(posedge sys_clk);
			n++;
		end
		if (n == 200) begin
			error_cnt++;
			complete_run();
		end
		chk({7'h0, n <= NVC + 2}, 8'h01);
		settle();
	endtask

	task automatic rd_reg(input logic [3:0] op, input logic [1:0] sel, ch, input logic [7:0] e);
		exp_q.push_back(e);
		cmd(op, sel, ch, 8'h00);
	endtask

	initial begin
		seed = 81;
		error_cnt = 0;
		checks = 0;
		rst_n = 1'b0;
		clk_en = 1'b1;
		write_protect_n = 1'b1;
		addr = 2'($random(seed));
		addr_pins <= addr;
		repeat (12) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (8) @(posedge sys_clk);
		for (int c = 0; c < 4; c++) begin
			wp[c] = qpwrb_pkg::SETTING_RST;
			for (int s = 0; s < 4; s++) st[s][c] = qpwrb_pkg::SETTING_RST;
		end
		chk_wp();
		chk({6'h0, standby, write_busy_flag}, 8'h02);
		// Direct wiper loads with random values, read back over the link.
		for (int c = 0; c < 4; c++) begin
			wp[c] = 8'($random(seed));
			cmd(qpwrb_pkg::OP_WRITE_WIPER, 2'h0, 2'(c), wp[c]);
			rd_reg(qpwrb_pkg::OP_READ_WIPER, 2'h0, 2'(c), wp[c]);
		end
		settle();
		chk_wp();
		// Frames for another slave address or device type are ignored.
		qpwrb_host_inst.frame({qpwrb_pkg::DEV_TYPE, 2'h1, addr}, {qpwrb_pkg::OP_WRITE_WIPER, 4'h0}, 8'h5a, 8, 0, 0);
		qpwrb_host_inst.frame({~qpwrb_pkg::DEV_TYPE, 2'h0, addr}, {qpwrb_pkg::OP_WRITE_WIPER, 4'h1}, 8'h5a, 8, 0, 0);
		settle();
		chk_wp();
		// Stepping at both ends saturates; the first frame pauses midway.
		wp[0] = 8'hfd;
		wp[3] = 8'h03;
		wp[1] = 8'h40;
		for (int c = 0; c < 4; c += 3) cmd(qpwrb_pkg::OP_WRITE_WIPER, 2'h0, 2'(c), wp[c]);
		cmd(qpwrb_pkg::OP_WRITE_WIPER, 2'h0, 2'h1, wp[1]);
		qpwrb_host_inst.frame({qpwrb_pkg::DEV_TYPE, 2'h0, addr}, {qpwrb_pkg::OP_INCDEC, 4'h0}, 8'hff, 8, 0, 1);
		cmd(qpwrb_pkg::OP_INCDEC, 2'h0, 2'h3, 8'h00);
		cmd(qpwrb_pkg::OP_INCDEC, 2'h0, 2'h1, 8'he0);
		wp[0] = 8'hff;
		wp[3] = 8'h00;
		wp[1] = 8'h3e;
		settle();
		chk_wp();
		// All four settings of channel 1, each a timed write.
		for (int s = 0; s < 4; s++) begin
			st[s][1] = 8'($random(seed));
			cmd(qpwrb_pkg::OP_WRITE_SET, 2'(s), 2'h1, st[s][1]);
			nv_wait(1'b1);
		end
		for (int s = 0; s < 4; s++) rd_reg(qpwrb_pkg::OP_READ_SET, 2'(s), 2'h1, st[s][1]);
		// Setting to wiper, single and global.
		cmd(qpwrb_pkg::OP_LOAD_WIPER, 2'h2, 2'h1, 8'h00);
		wp[1] = st[2][1];
		settle();
		chk_wp();
		cmd(qpwrb_pkg::OP_GLOAD_ALL, 2'h0, 2'h0, 8'h00);
		for (int c = 0; c < 4; c++) wp[c] = st[0][c];
		settle();
		chk_wp();
		// Wiper to setting, single and global.
		wp[2] = 8'($random(seed));
		cmd(qpwrb_pkg::OP_WRITE_WIPER, 2'h0, 2'h2, wp[2]);
		cmd(qpwrb_pkg::OP_SAVE_WIPER, 2'h3, 2'h2, 8'h00);
		nv_wait(1'b1);
		st[3][2] = wp[2];
		cmd(qpwrb_pkg::OP_GSAVE_ALL, 2'h1, 2'h0, 8'h00);
		nv_wait(1'b1);
		rd_reg(qpwrb_pkg::OP_READ_SET, 2'h3, 2'h2, st[3][2]);
		for (int c = 0; c < 4; c++) rd_reg(qpwrb_pkg::OP_READ_SET, 2'h1, 2'(c), wp[c]);
		// Write protect refuses the setting write and leaves it unchanged.
		@(posedge sys_clk);
		write_protect_n <= 1'b0;
		settle();
		cmd(qpwrb_pkg::OP_WRITE_SET, 2'h0, 2'h3, 8'h11);
		nv_wait(1'b0);
		write_protect_n <= 1'b1;
		rd_reg(qpwrb_pkg::OP_READ_SET, 2'h0, 2'h3, st[0][3]);
		rd_reg(qpwrb_pkg::OP_READ_STATUS, 2'h0, 2'h0, 8'h00);
		settle();
		chk({7'h0, exp_q.size() == 0}, 8'h01);
		complete_run();
	end
endmodule
